// >>> rtl/fcs_pkg.sv
/*
 * Constants shared by the flash checksum scanner: register indices, field
 * positions, mode and section codes, reset values and the scan phases.
 * Assumes a 32-bit classic Wishbone bus, one register per aligned word.
 */
package fcs_pkg;

    // register indices; byte address is four times the index
    localparam logic [1:0] IDX_CTRL_A = 2'h0;
    localparam logic [1:0] IDX_CTRL_B = 2'h1;
    localparam logic [1:0] IDX_STATUS = 2'h2;
    localparam int         IDX_LSB    = 2;
    localparam int         IDX_MSB    = 3;

    // scan_control_a fields
    localparam int A_ENABLE_BIT = 0;
    localparam int A_FATAL_BIT  = 1;
    localparam int A_STROBE_BIT = 7;

    // scan_control_b fields
    localparam int B_SECT_LSB = 0;
    localparam int B_SECT_MSB = 1;
    localparam int B_MODE_LSB = 4;
    localparam int B_MODE_MSB = 5;

    // scan_status fields
    localparam int S_BUSY_BIT = 0;
    localparam int S_PASS_BIT = 1;

    // access modes
    localparam logic [1:0] MODE_PRIORITY   = 2'h0;
    localparam logic [1:0] MODE_BACKGROUND = 2'h2;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h3;

    // section selects
    localparam logic [1:0] SECT_FLASH            = 2'h0;
    localparam logic [1:0] SECT_LOADER_AND_PROG  = 2'h1;
    localparam logic [1:0] SECT_LOADER           = 2'h2;

    // reset values
    localparam logic [1:0]  RST_MODE    = 2'h0;
    localparam logic [1:0]  RST_SECT    = 2'h0;
    localparam logic        RST_PASS    = 1'b1;
    localparam logic [15:0] CRC_INIT    = 16'hFFFF;
    localparam logic [15:0] CRC_POLY    = 16'h1021;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    typedef enum logic [0:0] {
        PH_IDLE,
        PH_FETCH
    } fcs_phase_t;

endpackage : fcs_pkg

// >>> rtl/fcs_crc_step.sv
/*
 * One byte step of the 16-bit checksum, most significant bit first.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module fcs_crc_step (
    input  wire logic [15:0] crcIn,
    input  wire logic [7:0]  dataIn,
    output logic      [15:0] crcOut
);
    always_comb begin
        logic [15:0] c;
        c = crcIn;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ dataIn[i]) begin
                c = {c[14:0], 1'b0} ^ fcs_pkg::CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crcOut = c;
    end
endmodule : fcs_crc_step

// >>> rtl/fcs_scanner.sv
/*
 * Flash checksum scanner: three 8-bit registers on classic Wishbone, a
 * byte fetch port toward the flash arbiter, and a sticky fatal request.
 * Assumes the arbiter answers a held request with a one-cycle grant that
 * carries the byte at flashAddr, all on clk_sys.
 */
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// R1: strobe reset clears control and status registers, except fatal enable, next cycle; never stored.
// R2: with fatal enable clear, strobe reset acts even while busy.
// R3: with fatal enable set, strobe reset is ignored while busy.
// R4: after the fatal request rises, control A writes are ignored.
// R5: with fatal enable set, any checksum failure raises the fatal request.
// R6: fatal enable clears only on system reset, not on strobe reset.
// R7: fatal enable may be set only while not busy.
// R8: writing enable one starts a check; bit stays one afterwards.
// R9: clearing enable stops only at section end; failure still flagged.
// R10: start-up scan leaves enable one, background mode, checked section.
// R11: control B writes ignored while busy or after fatal request.
// R12: mode field bits 5:4: 0 priority, 2 background, 3 continuous.
// R13: continuous mode restarts after each pass; stops on failure or stop.
// R14: section field: 0 whole flash, 1 loader plus program, 2 loader.
// R15: status register is read-only; writes do nothing.
// R16: pass flag one after reset, cleared on enabling, one means passed.
// R17: pass flag reads zero while a check runs.
// R18: busy flag in status bit zero is one while a check runs.
// R19: CCITT checksum, start 0xFFFF, bytes from zero, MSB first.
// R20: on failure pass clears; fatal request then holds until system reset.
// R21: scanner pauses while the CPU sleeps and resumes on wake.
// R22: bytes fetched by request/grant; high priority only in stall mode.
module fcs_scanner #(
    parameter int                ADDR_W      = 16,
    parameter logic [ADDR_W-1:0] FLASH_LAST  = 16'h1FFF,
    parameter logic [ADDR_W-1:0] PROG_LAST   = 16'h17FF,
    parameter logic [ADDR_W-1:0] LOADER_LAST = 16'h07FF
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   flashReq,
    output logic                   flashHighPri,
    output logic      [ADDR_W-1:0] flashAddr,
    input  wire logic              flashGrant,
    input  wire logic [7:0]        flashData,
    input  wire logic              cpuSleep,
    input  wire logic              initScanReq,
    input  wire logic [1:0]        initSection,
    output logic                   fatalReq
);

    typedef struct packed {
        logic              ack;
        logic [7:0]        rdData;
        logic              initTaken;
        logic              enable;
        logic              fatalEn;
        logic [1:0]        mode;
        logic [1:0]        section;
        logic              pass;
        logic              fatal;
        fcs_pkg::fcs_phase_t phase;
        logic              req;
        logic              highPri;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       crc;
    } fcs_state_t;

    fcs_state_t        st_reg;
    fcs_state_t        st_next;
    logic [15:0]       crcStep;
    logic              busy;
    logic              access;
    logic              wbWrite;
    logic [1:0]        regIdx;
    logic [ADDR_W-1:0] lastAddr;
    logic              byteTaken;
    logic              lastByte;
    logic              scanFail;
    logic              strobeOk;
    logic              startReq;
    logic              passRead;

    // R19: checksum byte step
    fcs_crc_step u_crc_step (
        .crcIn  (st_reg.crc),
        .dataIn (flashData),
        .crcOut (crcStep)
    );

    assign busy     = (st_reg.phase != fcs_pkg::PH_IDLE);
    assign access   = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign wbWrite  = access && wb_we_i && wb_sel_i[0];
    assign regIdx   = wb_adr_i[fcs_pkg::IDX_MSB:fcs_pkg::IDX_LSB];
    // R17: pass masked while running
    assign passRead = st_reg.pass && !busy;

    // R14: section end address
    always_comb begin
        unique case (st_reg.section)
            fcs_pkg::SECT_LOADER_AND_PROG: lastAddr = PROG_LAST;
            fcs_pkg::SECT_LOADER:          lastAddr = LOADER_LAST;
            // reserved code scans the whole flash
            default:                       lastAddr = FLASH_LAST;
        endcase
    end

    // R22: a byte counts only against our own held request
    assign byteTaken = busy && st_reg.req && flashGrant;
    assign lastByte  = byteTaken && (st_reg.addr == lastAddr);
    assign scanFail  = lastByte && (crcStep != fcs_pkg::CRC_RESIDUE);

    // R2: strobe accepted any time without fatal enable
    // R3: with fatal enable, only while idle
    assign strobeOk = !st_reg.fatalEn || !busy;

    always_comb begin
        st_next        = st_reg;
        st_next.ack    = 1'b0;
        st_next.rdData = 8'h00;
        startReq       = 1'b0;

        if (access) begin
            st_next.ack = 1'b1;
            if (!wb_we_i) begin
                unique case (regIdx)
                    fcs_pkg::IDX_CTRL_A: begin
                        st_next.rdData[fcs_pkg::A_ENABLE_BIT] = st_reg.enable;
                        st_next.rdData[fcs_pkg::A_FATAL_BIT]  = st_reg.fatalEn;
                    end
                    fcs_pkg::IDX_CTRL_B: begin
                        st_next.rdData[fcs_pkg::B_MODE_MSB:fcs_pkg::B_MODE_LSB]
                            = st_reg.mode;
                        st_next.rdData[fcs_pkg::B_SECT_MSB:fcs_pkg::B_SECT_LSB]
                            = st_reg.section;
                    end
                    fcs_pkg::IDX_STATUS: begin
                        // R18: busy reported in bit zero
                        st_next.rdData[fcs_pkg::S_BUSY_BIT] = busy;
                        st_next.rdData[fcs_pkg::S_PASS_BIT] = passRead;
                    end
                    // unmapped word reads zero
                    default: st_next.rdData = 8'h00;
                endcase
            end
        end

        // R21: no new fetch while the CPU sleeps
        // R19: fold each granted byte into the checksum
        if (byteTaken) begin
            st_next.crc  = crcStep;
            st_next.addr = st_reg.addr + 1'b1;
        end

        if (lastByte) begin
            if (scanFail) begin
                // R20: failure clears pass, scan halts
                st_next.pass  = 1'b0;
                st_next.phase = fcs_pkg::PH_IDLE;
                // R5: fatal request on failure when armed
                if (st_reg.fatalEn) begin
                    st_next.fatal = 1'b1;
                end
            end else begin
                st_next.pass = 1'b1;
                // R13: continuous restarts unless software stopped it
                // R9: cleared enable ends after this section
                if (st_reg.enable && st_reg.mode == fcs_pkg::MODE_CONTINUOUS)
                begin
                    st_next.addr = '0;
                    st_next.crc  = fcs_pkg::CRC_INIT;
                end else begin
                    st_next.phase = fcs_pkg::PH_IDLE;
                end
            end
        end

        // R10: start-up scan, caught once after reset release
        if (!st_reg.initTaken) begin
            st_next.initTaken = 1'b1;
            if (initScanReq) begin
                st_next.enable  = 1'b1;
                st_next.mode    = fcs_pkg::MODE_BACKGROUND;
                st_next.section = initSection;
                startReq        = 1'b1;
            end
        end

        // R4: control A frozen once the fatal request is up
        // R15: the status index has no write path
        if (wbWrite && regIdx == fcs_pkg::IDX_CTRL_A && !st_reg.fatal) begin
            if (wb_dat_i[fcs_pkg::A_STROBE_BIT]) begin
                // R1: strobe clears everything except fatal enable
                // R6: fatal enable survives the strobe
                if (strobeOk) begin
                    st_next.enable  = 1'b0;
                    st_next.mode    = fcs_pkg::RST_MODE;
                    st_next.section = fcs_pkg::RST_SECT;
                    st_next.pass    = 1'b0;
                    st_next.phase   = fcs_pkg::PH_IDLE;
                    st_next.addr    = '0;
                end
            end else begin
                // R7: arming only while idle, writing zero never disarms
                if (wb_dat_i[fcs_pkg::A_FATAL_BIT] && !busy) begin
                    st_next.fatalEn = 1'b1;
                end
                // R8: enable stays one; a one while idle starts a check
                st_next.enable = wb_dat_i[fcs_pkg::A_ENABLE_BIT];
                if (wb_dat_i[fcs_pkg::A_ENABLE_BIT] && !busy) begin
                    startReq = 1'b1;
                end
            end
        end

        // R11: control B locked while busy or after fatal request
        if (wbWrite && regIdx == fcs_pkg::IDX_CTRL_B && !busy
            && !st_reg.fatal) begin
            // R12: mode field; reserved code runs as a single background
            st_next.mode    = wb_dat_i[fcs_pkg::B_MODE_MSB:fcs_pkg::B_MODE_LSB];
            // R14: section select
            st_next.section = wb_dat_i[fcs_pkg::B_SECT_MSB:fcs_pkg::B_SECT_LSB];
        end

        // R16: enabling clears pass
        if (startReq) begin
            st_next.phase = fcs_pkg::PH_FETCH;
            st_next.addr  = '0;
            st_next.crc   = fcs_pkg::CRC_INIT;
            st_next.pass  = 1'b0;
        end

        // R21: request dropped during sleep, position kept for resume
        // R22: priority flag only in stall mode
        st_next.req     = (st_next.phase == fcs_pkg::PH_FETCH) && !cpuSleep;
        st_next.highPri = st_next.req
                          && (st_next.mode == fcs_pkg::MODE_PRIORITY);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg           <= '0;
            st_reg.mode      <= fcs_pkg::RST_MODE;
            st_reg.section   <= fcs_pkg::RST_SECT;
            // R16: pass set from reset
            st_reg.pass      <= fcs_pkg::RST_PASS;
            st_reg.phase     <= fcs_pkg::PH_IDLE;
            st_reg.crc       <= fcs_pkg::CRC_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_ack_o     = st_reg.ack;
    assign wb_dat_o     = {24'h000000, st_reg.rdData};
    assign flashReq     = st_reg.req;
    assign flashHighPri = st_reg.highPri;
    assign flashAddr    = st_reg.addr;
    assign fatalReq     = st_reg.fatal;

    // assertion helpers
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence sCtrlAWrite;
        wbWrite && regIdx == fcs_pkg::IDX_CTRL_A;
    endsequence

    sequence sCtrlBWrite;
        wbWrite && regIdx == fcs_pkg::IDX_CTRL_B;
    endsequence

    sequence sStrobeTaken;
        sCtrlAWrite ##0 (wb_dat_i[fcs_pkg::A_STROBE_BIT] && strobeOk
                         && !st_reg.fatal);
    endsequence

    a_strobe_clears: assert property ( // R1
        sStrobeTaken |=> (!st_reg.enable && st_reg.mode == 2'h0
                          && st_reg.section == 2'h0 && !busy
                          && !passRead))
        else $error("strobe reset did not clear registers");

    a_strobe_busy_blocked: assert property ( // R3
        sCtrlAWrite ##0 (wb_dat_i[fcs_pkg::A_STROBE_BIT] && st_reg.fatalEn
                         && busy && !lastByte) |=> busy)
        else $error("strobe reset acted while armed and busy");

    a_fatal_locks_scan_control_a: assert property ( // R4
        sCtrlAWrite ##0 st_reg.fatal |=> $stable(st_reg.enable)
                                        && $stable(st_reg.mode))
        else $error("control A write took effect after fatal");

    a_fatal_on_fail: assert property ( // R5
        scanFail && st_reg.fatalEn |=> fatalReq && !passRead)
        else $error("failure with fatal enable gave no fatal request");

    a_fatal_en_sticky: assert property ( // R6
        st_reg.fatalEn |=> st_reg.fatalEn)
        else $error("fatal enable cleared without system reset");

    a_fatal_en_idle: assert property ( // R7
        $rose(st_reg.fatalEn) |-> !$past(busy))
        else $error("fatal enable set while busy");

    a_scan_control_b_locked: assert property ( // R11
        sCtrlBWrite ##0 (busy || st_reg.fatal)
        |=> $stable(st_reg.mode) && $stable(st_reg.section))
        else $error("control B changed while locked");

    a_fatal_held: assert property ( // R20
        fatalReq |=> fatalReq [*8])
        else $error("fatal request dropped before system reset");

    a_start_clears_pass: assert property ( // R16
        startReq |=> busy && !st_reg.pass)
        else $error("start did not clear pass and set busy");

    a_prio_only_stall: assert property ( // R22
        flashHighPri |-> flashReq && st_reg.mode == fcs_pkg::MODE_PRIORITY)
        else $error("high priority outside stall mode");

    a_sleep_no_fetch: assert property ( // R21
        cpuSleep |=> !flashReq)
        else $error("fetch request during sleep");

    a_stop_at_end: assert property ( // R9
        lastByte && !st_reg.enable |=> !busy)
        else $error("scan went on after enable was cleared");

    // a write on the last byte may cancel the restart, so it is left out
    a_cont_restart: assert property ( // R13
        lastByte && !scanFail && st_reg.enable && !wbWrite
        && st_reg.mode == fcs_pkg::MODE_CONTINUOUS
        |=> busy && flashAddr == '0)
        else $error("continuous scan did not restart at zero");

    a_status_busy: assert property ( // R18
        access && !wb_we_i && regIdx == fcs_pkg::IDX_STATUS
        |=> wb_dat_o[fcs_pkg::S_BUSY_BIT] == $past(busy))
        else $error("status busy bit does not follow the scan");

endmodule : fcs_scanner

// >>> tb/fcs_flash_model.sv
/*
 * Flash arbiter and byte store on the scanner's fetch port.
 * Assumes the scanner holds flashReq while it waits, all on clk_sys.
 */
`timescale 1ns/1ps
module fcs_flash_model (
    input  wire logic        clk_sys,
    input  wire logic        flashReq,
    input  wire logic        flashHighPri,
    input  wire logic [15:0] flashAddr,
    input  wire logic        stall,
    output logic             flashGrant,
    output logic      [7:0]  flashData
);
    logic [7:0] mem [0:15];
    logic [7:0] lastData;
    initial begin
        flashGrant = 1'b0;
        lastData   = 8'h00;
    end
    // request and grant
    // cpu steals random cycles unless the scan has priority
    always @(posedge clk_sys) begin
        flashGrant <= flashReq && !stall &&
                      (flashHighPri || $urandom_range(1) == 1);
        if (flashGrant) lastData <= mem[flashAddr[3:0]];
    end
    // released bus shows the inverse, never a stale byte
    assign flashData = flashGrant ? mem[flashAddr[3:0]] : ~lastData;
endmodule : fcs_flash_model

// >>> tb/tb_flash_checksum_scanner.sv
/*
 * Self-checking bench for the flash checksum scanner.
 * Assumes one clk_sys domain and the fetch-port model beside the block.
 */
`timescale 1ns/1ps
module tb_flash_checksum_scanner;
    logic        clk_sys     = 1'b0;
    logic        rst         = 1'b1;
    logic        wbCyc       = 1'b0;
    logic        wbStb       = 1'b0;
    logic        wbWe        = 1'b0;
    logic [3:0]  wbAdr       = 4'h0;
    logic [3:0]  wbSel       = 4'h0;
    logic [31:0] wbDatI      = 32'h0;
    logic        cpuSleep    = 1'b0;
    logic        initScanReq = 1'b0;
    logic [1:0]  initSection = 2'h0;
    logic        stall       = 1'b0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        flashReq;
    logic        flashHighPri;
    logic [15:0] flashAddr;
    logic        flashGrant;
    logic [7:0]  flashData;
    logic        fatalReq;
    logic [31:0] expQ [$];
    logic [1:0]  modes [3] = '{fcs_pkg::MODE_PRIORITY,
                               fcs_pkg::MODE_BACKGROUND,
                               fcs_pkg::MODE_CONTINUOUS};
    logic [7:0]  b;
    int          n_errors = 0;
    int          compares = 0;

    always #20 clk_sys = ~clk_sys;

    fcs_scanner #(.ADDR_W(16), .FLASH_LAST(16'h000F),
        .PROG_LAST(16'h0007), .LOADER_LAST(16'h0003)) DUT (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .flashReq(flashReq), .flashHighPri(flashHighPri),
        .flashAddr(flashAddr), .flashGrant(flashGrant),
        .flashData(flashData), .cpuSleep(cpuSleep),
        .initScanReq(initScanReq), .initSection(initSection),
        .fatalReq(fatalReq));

    fcs_flash_model flash (.clk_sys(clk_sys), .flashReq(flashReq),
        .flashHighPri(flashHighPri), .flashAddr(flashAddr),
        .stall(stall), .flashGrant(flashGrant), .flashData(flashData));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // one classic cycle, held until ack is sampled
    task automatic wr(input logic we, input logic [3:0] a,
                      input logic [7:0] d);
        @(posedge clk_sys);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= a;
        wbSel  <= {3'($urandom), 1'b1};
        wbDatI <= {24'($urandom), d};
        // no local limit: only the watchdog ends a hung cycle
        do begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe  <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back({24'h0, e});
        wr(1'b0, a, 8'h00);
    endtask : rd

    task automatic start(input logic [7:0] ctl);
        wr(1'b1, 4'h4, ctl);
        wr(1'b1, 4'h0, 8'h01);
    endtask : start

    task automatic wait_idle();
        int n;
        n = 0;
        // request may still be parked by sleep; let it come back first
        repeat (2) @(posedge clk_sys);
        while (flashReq !== 1'b0 && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 500) begin
            n_errors++;
            $display("unexpected at %0t: scan never ended", $time);
        end
        repeat (2) @(posedge clk_sys);
    endtask : wait_idle

    // checksum in the last two bytes, msb first
    task automatic fill(input logic [1:0] s, input logic good);
        int          last;
        logic [15:0] c;
        last = (s == 2'h2) ? 3 : (s == 2'h1) ? 7 : 15;
        c = 16'hFFFF;
        for (int i = 0; i <= last - 2; i++) begin
            flash.mem[i] = 8'($urandom);
            c = c ^ {flash.mem[i], 8'h00};
            for (int k = 0; k < 8; k++)
                c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        end
        flash.mem[last-1] = c[15:8];
        flash.mem[last]   = c[7:0] ^ {7'h0, !good};
    endtask : fill

    always @(posedge clk_sys) begin
        if (wbAck === 1'b1 && wbWe === 1'b0) begin
            if (expQ.size() == 0) begin
                n_errors++;
                $display("unexpected at %0t: read with no note", $time);
            end else begin
                check(wbDatO, expQ.pop_front());
            end
        end
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        void'($urandom(20));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, read-only status, unmapped word
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        wr(1'b1, 4'h8, 8'hFD);
        rd(4'h8, 8'h02);
        rd(4'hC, 8'h00);
        $display("test reset done");
        for (int m = 0; m < 3; m++) for (int s = 0; s < 3; s++) begin
            b = {2'b00, modes[m], 2'b00, 2'(s)};
            fill(2'(s), 1'b1);
            stall <= 1'b1;
            start(b);
            rd(4'h8, 8'h01);
            wr(1'b1, 4'h4, 8'h12);
            rd(4'h4, b);
            check(flashHighPri, modes[m] == 2'h0);
            check(flashAddr, 16'h0000);
            cpuSleep <= 1'b1;
            repeat (3) @(posedge clk_sys);
            check(flashReq, 1'b0);
            cpuSleep <= 1'b0;
            stall    <= 1'b0;
            if (modes[m] == 2'h3) begin
                repeat (200) @(posedge clk_sys);
                rd(4'h8, 8'h01);
                wr(1'b1, 4'h0, 8'h00);
            end
            wait_idle();
            rd(4'h8, 8'h02);
            rd(4'h0, {7'h0, modes[m] != 2'h3});
        end
        // reserved codes: single background pass over all flash
        fill(2'h3, 1'b1);
        start(8'h13);
        check(flashHighPri, 1'b0);
        check(flashReq, 1'b1);
        rd(4'h4, 8'h13);
        wait_idle();
        rd(4'h8, 8'h02);
        rd(4'h0, 8'h01);
        $display("test modes done");
        fill(2'h0, 1'b1);
        stall <= 1'b1;
        // strobe clears all while busy, unarmed
        start(8'h20);
        wr(1'b1, 4'h0, 8'h81);
        rd(4'h8, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'h0, 8'h00);
        start(8'h20);
        wr(1'b1, 4'h0, 8'h03);
        rd(4'h0, 8'h01);
        stall <= 1'b0;
        wait_idle();
        wr(1'b1, 4'h0, 8'h02);
        stall <= 1'b1;
        start(8'h20);
        wr(1'b1, 4'h0, 8'h80);
        rd(4'h8, 8'h01);
        stall <= 1'b0;
        wait_idle();
        rd(4'h8, 8'h02);
        check(fatalReq, 1'b0);
        wr(1'b1, 4'h0, 8'h80);
        rd(4'h0, 8'h02);
        $display("test strobe done");
        fill(2'h2, 1'b0);
        stall <= 1'b1;
        start(8'h32);
        wr(1'b1, 4'h0, 8'h02);
        stall <= 1'b0;
        wait_idle();
        check(fatalReq, 1'b1);
        rd(4'h8, 8'h00);
        wr(1'b1, 4'h0, 8'h81);
        wr(1'b1, 4'h4, 8'h21);
        rd(4'h0, 8'h02);
        rd(4'h4, 8'h32);
        check(fatalReq, 1'b1);
        $display("test fatal done");
        fill(2'h1, 1'b1);
        initScanReq <= 1'b1;
        initSection <= 2'h1;
        rst         <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        initScanReq <= 1'b0;
        repeat (2) @(posedge clk_sys);
        wait_idle();
        rd(4'h0, 8'h01);
        rd(4'h4, 8'h21);
        rd(4'h8, 8'h02);
        check(fatalReq, 1'b0);
        $display("test startup done");
        stop_test();
    end
endmodule : tb_flash_checksum_scanner
